/* design/ues_defs.svh */
// ues_defs.svh: error codes, timing counts and log sizes of the unit error supervisor
// assumes: included by bare name from the design module, the checker and the bench
`ifndef UES_DEFS_SVH
`define UES_DEFS_SVH

// posted error codes
`define UES_CODE_NONE        16'h0000
`define UES_CODE_REFRESH     16'h0007
`define UES_CODE_HOST_FAULT  16'h0009
`define UES_CODE_SLOWDOWN    16'h000A
`define UES_CODE_SETUP       16'h000B
`define UES_CODE_POS_DATA    16'h000C
`define UES_CODE_LOG_CORRUPT 16'h000D

// refresh watchdog: longest gap between refresh strobes, in microseconds
`define UES_REFRESH_TIMEOUT_US 1000
`define UES_CLK_MHZ            20
`define UES_REFRESH_CYCLES     (`UES_REFRESH_TIMEOUT_US * `UES_CLK_MHZ)

// error log depth and pointer width
`define UES_LOG_DEPTH 16
`define UES_LOG_AW    4

`endif

/* design/ues_pkg.sv */
// ues_pkg.sv: types of the unit error supervisor
// assumes: nothing beyond the definitions header
package ues_pkg;

  // stop type posted with an error
  typedef enum logic [1:0] {
    UES_STOP_NONE,
    UES_STOP_DECEL,
    UES_STOP_EMERG
  } ues_stop_t;

  // status word handed to the host
  typedef struct packed {
    logic        active;
    ues_stop_t   stop;
    logic [15:0] code;
  } ues_status_t;

  // sticky error sources, one bit each
  typedef struct packed {
    logic log_corrupt;
    logic pos_data;
    logic setup;
    logic slowdown;
    logic host_fault;
    logic refresh;
  } ues_err_t;

  // log scrub sequencer
  typedef enum logic [1:0] {
    UES_LOG_IDLE,
    UES_LOG_CHECK,
    UES_LOG_ERASE
  } ues_log_state_t;

endpackage

/* design/ues_supervisor.sv */
// ues_supervisor.sv: unit error supervisor for a motion control module
// assumes: pendant and host status inputs are asynchronous and are synchronised here;
// refresh, reset, restart and transfer strobes come from logic on core_clk_i
`timescale 1ns/1ps
`include "ues_defs.svh"
`default_nettype none

module ues_supervisor #(
  parameter int REFRESH_CYCLES = `UES_REFRESH_CYCLES,
  parameter int LOG_DEPTH      = `UES_LOG_DEPTH
) (
  input  wire logic                  core_clk_i,
  input  wire logic                  rst_i,
  input  wire logic                  refresh_i,
  input  wire logic                  host_fault_error_i,
  input  wire logic                  pendant_slowdown_error_i,
  input  wire logic                  param_new_i,
  input  wire logic [31:0]           param_data_i,
  input  wire logic                  host_block_read_i,
  input  wire logic                  host_block_read_bad_i,
  input  wire logic                  log_bad_i,
  input  wire logic                  err_reset_i,
  input  wire logic                  host_restart_i,
  input  wire logic                  log_wr_i,
  output var  ues_pkg::ues_status_t  status_o,
  output logic                       emerg_stop_o,
  output logic                       pendant_slowdown_error_o,
  output logic [31:0]                active_param_o,
  output logic                       log_busy_o
);

  // -----------------------------------------------------------------
  // input synchronisers
  // -----------------------------------------------------------------
  logic [1:0] sync1_q, sync1_d, sync2_q, sync2_d;
  logic       host_fault_s, slowdown_s;

  // two stages for the asynchronous host fault and pendant key
  always_comb begin
    sync1_d = {host_fault_error_i, pendant_slowdown_error_i};
    sync2_d = sync1_q;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      sync1_q <= 2'h0;
      sync2_q <= 2'h0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
    end
  end

  assign host_fault_s = sync2_q[1];
  assign slowdown_s   = sync2_q[0];

  // -----------------------------------------------------------------
  // refresh watchdog
  // -----------------------------------------------------------------
  logic [31:0] wd_q, wd_d;
  logic        wd_expire;

  // counts cycles since the last refresh strobe or restart
  always_comb begin
    wd_d      = wd_q;
    wd_expire = 1'b0;
    if (refresh_i || host_restart_i) begin
      wd_d = 32'h0;
    end else if (wd_q >= 32'(REFRESH_CYCLES - 1)) begin
      wd_expire = 1'b1;
    end else begin
      wd_d = wd_q + 32'h1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wd_q <= 32'h0;
    end else begin
      wd_q <= wd_d;
    end
  end

  // -----------------------------------------------------------------
  // error log with power-up check and scrub
  // -----------------------------------------------------------------
  logic [15:0]            log_mem [LOG_DEPTH];
  logic [`UES_LOG_AW-1:0] wptr_q, wptr_d, scrub_q, scrub_d;
  ues_pkg::ues_log_state_t lst_q, lst_d;
  logic                   log_corrupt_evt;
  logic                   scrub_we;
  logic                   rec_we;

  // after reset or restart, check the log once, erase it when bad
  always_comb begin
    lst_d           = lst_q;
    scrub_d         = scrub_q;
    log_corrupt_evt = 1'b0;
    scrub_we        = 1'b0;
    unique case (lst_q)
      ues_pkg::UES_LOG_IDLE: begin
        if (host_restart_i) begin
          lst_d = ues_pkg::UES_LOG_CHECK;
        end
      end
      ues_pkg::UES_LOG_CHECK: begin
        if (log_bad_i) begin
          log_corrupt_evt = 1'b1;
          scrub_d         = '0;
          lst_d           = ues_pkg::UES_LOG_ERASE;
        end else begin
          lst_d = ues_pkg::UES_LOG_IDLE;
        end
      end
      ues_pkg::UES_LOG_ERASE: begin
        scrub_we = 1'b1;
        scrub_d  = scrub_q + 1'b1;
        if (scrub_q == `UES_LOG_AW'(LOG_DEPTH - 1)) begin
          lst_d = ues_pkg::UES_LOG_IDLE;
        end
      end
      default: begin
        lst_d = ues_pkg::UES_LOG_IDLE;                     // unused code falls back to idle
      end
    endcase
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      lst_q   <= ues_pkg::UES_LOG_CHECK;
      scrub_q <= '0;
    end else begin
      lst_q   <= lst_d;
      scrub_q <= scrub_d;
    end
  end

  // -----------------------------------------------------------------
  // sticky error flags
  // -----------------------------------------------------------------
  ues_pkg::ues_err_t err_q, err_d, err_set, err_new;

  // sets win over clears; refresh and host fault clear only on restart, the rest also on error reset
  always_comb begin
    err_set             = '0;
    err_set.refresh     = wd_expire;
    err_set.host_fault  = host_fault_s;
    err_set.slowdown    = slowdown_s;
    err_set.setup       = param_new_i;
    err_set.pos_data    = host_block_read_i && host_block_read_bad_i;
    err_set.log_corrupt = log_corrupt_evt;
    err_d = err_q;
    if (host_restart_i) begin
      err_d = '0;
    end else if (err_reset_i) begin
      err_d.slowdown    = 1'b0;
      err_d.setup       = 1'b0;
      err_d.pos_data    = 1'b0;
      err_d.log_corrupt = 1'b0;
    end
    err_d   = err_d | err_set;
    err_new = err_set & ~err_q;
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      err_q <= '0;
    end else begin
      err_q <= err_d;
    end
  end

  // -----------------------------------------------------------------
  // posted code and stop outputs
  // -----------------------------------------------------------------
  ues_pkg::ues_status_t st_q, st_d;
  logic                 emerg_q, emerg_d, decel_q, decel_d;

  // code of the highest-priority source set in e
  function automatic logic [15:0] ues_code(input ues_pkg::ues_err_t e);
    if (e.host_fault)       return `UES_CODE_HOST_FAULT;
    else if (e.refresh)     return `UES_CODE_REFRESH;
    else if (e.log_corrupt) return `UES_CODE_LOG_CORRUPT;
    else if (e.pos_data)    return `UES_CODE_POS_DATA;
    else if (e.setup)       return `UES_CODE_SETUP;
    else if (e.slowdown)    return `UES_CODE_SLOWDOWN;
    else                    return `UES_CODE_NONE;
  endfunction

  // true while the flag behind a posted code is still set
  function automatic logic ues_live(input ues_pkg::ues_err_t e, input logic [15:0] c);
    return (e.host_fault  && (c == `UES_CODE_HOST_FAULT))  ||
           (e.refresh     && (c == `UES_CODE_REFRESH))     ||
           (e.log_corrupt && (c == `UES_CODE_LOG_CORRUPT)) ||
           (e.pos_data    && (c == `UES_CODE_POS_DATA))    ||
           (e.setup       && (c == `UES_CODE_SETUP))       ||
           (e.slowdown    && (c == `UES_CODE_SLOWDOWN));
  endfunction

  // latest code stands until its own flag is cleared
  always_comb begin
    st_d    = st_q;
    emerg_d = err_d.host_fault;
    decel_d = |{err_d.refresh, err_d.slowdown, err_d.setup,
                err_d.pos_data, err_d.log_corrupt};
    if (|err_new) begin
      st_d.active = 1'b1;
      st_d.code   = ues_code(err_new);
      st_d.stop   = err_new.host_fault ? ues_pkg::UES_STOP_EMERG
                                       : ues_pkg::UES_STOP_DECEL;
    end else if (st_q.active && !ues_live(err_d, st_q.code)) begin
      st_d.active = |err_d;
      st_d.code   = ues_code(err_d);
      st_d.stop   = !(|err_d) ? ues_pkg::UES_STOP_NONE
                  : err_d.host_fault ? ues_pkg::UES_STOP_EMERG
                                     : ues_pkg::UES_STOP_DECEL;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      st_q    <= '{active: 1'b0, stop: ues_pkg::UES_STOP_NONE, code: `UES_CODE_NONE};
      emerg_q <= 1'b0;
      decel_q <= 1'b0;
    end else begin
      st_q    <= st_d;
      emerg_q <= emerg_d;
      decel_q <= decel_d;
    end
  end

  // -----------------------------------------------------------------
  // log writes: new codes recorded, scrub writes zero
  // -----------------------------------------------------------------
  assign rec_we = (|err_new) && !scrub_we;

  always_comb begin
    wptr_d = wptr_q;
    if (scrub_we) begin
      wptr_d = '0;
    end else if (rec_we || log_wr_i) begin
      wptr_d = wptr_q + 1'b1;
    end
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      wptr_q <= '0;
    end else begin
      wptr_q <= wptr_d;
    end
    if (scrub_we) begin
      log_mem[scrub_q] <= `UES_CODE_NONE;
    end else if (rec_we) begin
      log_mem[wptr_q] <= ues_code(err_new);
    end
  end

  // -----------------------------------------------------------------
  // parameter set: new values wait for a reset
  // -----------------------------------------------------------------
  logic [31:0] pend_q, pend_d, act_q, act_d;
  logic        boot_q, boot_d, busy_q, busy_d;

  // pending set loads into the active set only in the first cycle after reset
  always_comb begin
    pend_d = param_new_i ? param_data_i : pend_q;
    act_d  = boot_q ? pend_q : act_q;
    boot_d = 1'b0;
    busy_d = (lst_d != ues_pkg::UES_LOG_IDLE);
  end

  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      boot_q <= 1'b1;
      busy_q <= 1'b1;
    end else begin
      pend_q <= pend_d;
      act_q  <= act_d;
      boot_q <= boot_d;
      busy_q <= busy_d;
    end
  end

  // outputs straight from flip-flops
  assign status_o       = st_q;
  assign emerg_stop_o   = emerg_q;
  assign pendant_slowdown_error_o   = decel_q;
  assign active_param_o = act_q;
  assign log_busy_o     = busy_q;

endmodule

`default_nettype wire

/* sim/ues_host_model.sv */
// ues_host_model.sv: host controller model, periodic refresh and position resend
// assumes: runs on the supervisor clock
`timescale 1ns/1ps
`default_nettype none

module ues_host_model (
  input  wire logic clk_i,
  input  wire logic rst_i,
  input  wire logic en_i,
  input  wire logic err_reset_i,
  output logic      refresh_o,
  output logic      resend_o
);
  logic [2:0] cnt_q;
  logic [2:0] cnt_d;
  logic       ref_d;
  logic       rsd_d;

  // refresh every eight cycles while enabled, resend after an error reset
  always_comb begin
    cnt_d = (rst_i || !en_i) ? 3'h0 : cnt_q + 3'h1;
    ref_d = en_i && !rst_i && (cnt_q == 3'h7);
    rsd_d = err_reset_i && !rst_i;
  end

  always_ff @(posedge clk_i) begin
    cnt_q     <= cnt_d;
    refresh_o <= ref_d;
    resend_o  <= rsd_d;
  end
endmodule

`default_nettype wire

/* sim/ues_supervisor_chk.sv */
// ues_supervisor_chk.sv: port checker of the unit error supervisor
// assumes: bound to ues_supervisor, one clock domain
`timescale 1ns/1ps
`include "ues_defs.svh"
`default_nettype none

module ues_supervisor_chk #(
  parameter int REFRESH_CYCLES = `UES_REFRESH_CYCLES
) (
  input wire logic                 core_clk_i,
  input wire logic                 rst_i,
  input wire logic                 refresh_i,
  input wire logic                 host_fault_error_i,
  input wire logic                 pendant_slowdown_error_i,
  input wire logic                 param_new_i,
  input wire logic                 host_block_read_i,
  input wire logic                 host_block_read_bad_i,
  input wire logic                 log_bad_i,
  input wire logic                 err_reset_i,
  input wire logic                 host_restart_i,
  input wire ues_pkg::ues_status_t status_o,
  input wire logic                 emerg_stop_o,
  input wire logic                 pendant_slowdown_error_o,
  input wire logic                 log_busy_o
);
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);

  // cycles since the last refresh strobe or restart
  int   gap_q;
  int   gap_d;
  logic stop_any;
  always_comb begin
    gap_d    = (refresh_i || host_restart_i) ? 0 : gap_q + 1;
    stop_any = emerg_stop_o || pendant_slowdown_error_o;
  end
  always_ff @(posedge core_clk_i) begin
    gap_q <= rst_i ? 0 : gap_d;
  end

  property p_wd;
    gap_q > REFRESH_CYCLES + 2 |-> pendant_slowdown_error_o && status_o.active;
  endproperty
  a_wd: assert property (p_wd) else $error("watchdog code missing");
  property p_wd_hold;
    status_o.code == `UES_CODE_REFRESH && err_reset_i && !host_restart_i && !param_new_i
      && !(host_block_read_i && host_block_read_bad_i)
      |=> status_o.code inside {`UES_CODE_REFRESH, `UES_CODE_HOST_FAULT};
  endproperty
  a_wd_hold: assert property (p_wd_hold) else $error("refresh code cleared");
  property p_hf;
    !host_fault_error_i && !emerg_stop_o ##1 (host_fault_error_i && !host_restart_i)[*4]
      |-> emerg_stop_o && status_o.code == 16'h0009;
  endproperty
  a_hf: assert property (p_hf) else $error("host fault not posted");
  property p_hf_hold;
    emerg_stop_o && err_reset_i && !host_restart_i |=> emerg_stop_o;
  endproperty
  a_hf_hold: assert property (p_hf_hold) else $error("host fault cleared");
  property p_sd;
    (pendant_slowdown_error_i && !host_restart_i && !err_reset_i)[*4] |-> stop_any;
  endproperty
  a_sd: assert property (p_sd) else $error("slowdown not posted");
  property p_set;
    param_new_i && !host_restart_i |=> stop_any && status_o.active;
  endproperty
  a_set: assert property (p_set) else $error("setup not posted");
  property p_pos;
    host_block_read_i && host_block_read_bad_i && !host_restart_i |=> stop_any;
  endproperty
  a_pos: assert property (p_pos) else $error("bad read not posted");
  property p_log;
    $fell(rst_i) && log_bad_i |=> log_busy_o[*8] ##[1:12] !log_busy_o && status_o.code == 16'h000D;
  endproperty
  a_log: assert property (p_log) else $error("log scrub wrong");
endmodule

bind ues_supervisor ues_supervisor_chk #(.REFRESH_CYCLES(REFRESH_CYCLES)) u_chk (
  .core_clk_i(core_clk_i), .rst_i(rst_i), .refresh_i(refresh_i),
  .host_fault_error_i(host_fault_error_i), .pendant_slowdown_error_i(pendant_slowdown_error_i),
  .param_new_i(param_new_i), .host_block_read_i(host_block_read_i),
  .host_block_read_bad_i(host_block_read_bad_i), .log_bad_i(log_bad_i),
  .err_reset_i(err_reset_i), .host_restart_i(host_restart_i), .status_o(status_o),
  .emerg_stop_o(emerg_stop_o), .pendant_slowdown_error_o(pendant_slowdown_error_o), .log_busy_o(log_busy_o));

`default_nettype wire

/* sim/ues_supervisor_tb.sv */
// ues_supervisor_tb.sv: self-checking bench of the unit error supervisor
// assumes: package, design, host model and checker compiled first
`timescale 1ns/1ps
`include "ues_defs.svh"
`default_nettype none

module ues_supervisor_tb;
  logic                 core_clk_i = 1'b0;
  logic                 rst_i = 1'b1;
  logic                 hf = 1'b0;
  logic                 sd = 1'b0;
  logic                 pn = 1'b0;
  logic                 rd = 1'b0;
  logic                 bad = 1'b0;
  logic                 lb = 1'b1;
  logic                 er = 1'b0;
  logic                 rs = 1'b0;
  logic                 en = 1'b0;
  logic [31:0]          pd = 32'h0;
  logic [31:0]          p1;
  logic [31:0]          act;
  logic                 ref_s;
  logic                 rsd;
  logic                 emg;
  logic                 dec;
  logic                 busy;
  ues_pkg::ues_status_t st;
  int                   n_fail = 0;
  int                   samples_checked = 0;
  int                   cyc = 0;
  int                   k;
  bit                   f_ref, f_hf, f_sd, f_set, f_pos, f_log;
  logic [15:0]          lc = 16'h0;

  always #25 core_clk_i = ~core_clk_i;

  ues_supervisor #(.REFRESH_CYCLES(16)) u_dut (
    .core_clk_i(core_clk_i), .rst_i(rst_i), .refresh_i(ref_s), .host_fault_error_i(hf),
    .pendant_slowdown_error_i(sd), .param_new_i(pn), .param_data_i(pd),
    .host_block_read_i(rd | rsd), .host_block_read_bad_i(bad), .log_bad_i(lb),
    .err_reset_i(er), .host_restart_i(rs), .log_wr_i(1'b0), .status_o(st),
    .emerg_stop_o(emg), .pendant_slowdown_error_o(dec), .active_param_o(act), .log_busy_o(busy));

  ues_host_model u_host (.clk_i(core_clk_i), .rst_i(rst_i), .en_i(en), .err_reset_i(er),
    .refresh_o(ref_s), .resend_o(rsd));

  task automatic close_out();
    if (n_fail == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %s exp %h seen %h", nm, exp, seen);
    end
  endtask

  // model: is the flag behind a code still set
  function automatic bit live(input logic [15:0] c);
    return (c == `UES_CODE_HOST_FAULT && f_hf) || (c == `UES_CODE_REFRESH && f_ref) ||
           (c == `UES_CODE_LOG_CORRUPT && f_log) || (c == `UES_CODE_POS_DATA && f_pos) ||
           (c == `UES_CODE_SETUP && f_set) || (c == `UES_CODE_SLOWDOWN && f_sd);
  endfunction

  // latest code stands while its flag does, else highest remaining by priority
  task automatic cmp();
    logic [15:0] c;
    logic [31:0] s;
    c = f_hf ? `UES_CODE_HOST_FAULT : f_ref ? `UES_CODE_REFRESH : f_log ? `UES_CODE_LOG_CORRUPT :
        f_pos ? `UES_CODE_POS_DATA : f_set ? `UES_CODE_SETUP : f_sd ? `UES_CODE_SLOWDOWN : 16'h0;
    if (!live(lc)) lc = c;
    s = (lc == 16'h0) ? ues_pkg::UES_STOP_NONE :
        (lc == `UES_CODE_HOST_FAULT) ? ues_pkg::UES_STOP_EMERG : ues_pkg::UES_STOP_DECEL;
    @(negedge core_clk_i);
    chk("code", st.code, lc);
    chk("active", st.active, lc != 16'h0);
    chk("stop", st.stop, s);
    chk("emerg", emg, f_hf);
    if (!f_hf) chk("decel", dec, c != 16'h0);
    @(posedge core_clk_i);
  endtask

  // one-cycle strobe: 0 setup, 1 bad read, 2 error reset, 3 restart
  task automatic ev(input int e);
    @(posedge core_clk_i);
    pn <= (e == 0);
    rd <= (e == 1);
    bad <= (e == 1);
    er <= (e == 2);
    rs <= (e == 3);
    @(posedge core_clk_i);
    {pn, rd, bad, er, rs} <= 5'h00;
  endtask

  task automatic boot();
    repeat (16) @(posedge core_clk_i);
    rst_i <= 1'b0;
    en <= 1'b1;
    @(posedge core_clk_i);
    repeat (40) if (busy !== 1'b0) @(negedge core_clk_i);
    chk("busy", busy, 0);
  endtask

  always @(posedge core_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      close_out();
    end
  end

  initial begin
    void'($urandom(32'hfa91528f));
    boot();
    lc = `UES_CODE_LOG_CORRUPT;
    f_log = 1;
    cmp();
    lb <= 1'b0;
    ev(2);
    f_log = 0;
    cmp();
    for (int i = 0; i < 24; i++) begin
      k = (i == 23) ? 0 : $urandom_range(2);
      p1 = $urandom();
      pd <= p1;
      ev(k);
      if (k == 0 && !f_set) lc = `UES_CODE_SETUP;
      if (k == 1 && !f_pos) lc = `UES_CODE_POS_DATA;
      if (k == 0) f_set = 1;
      if (k == 1) f_pos = 1;
      if (k == 2) {f_set, f_pos} = 2'b00;
      cmp();
    end
    rst_i <= 1'b1;
    en <= 1'b0;
    {f_set, f_pos} = 2'b00;
    boot();
    chk("act_new", act, p1);
    @(posedge core_clk_i);
    pd <= ~p1;
    ev(0);
    lc = `UES_CODE_SETUP;
    f_set = 1;
    cmp();
    chk("act_old", act, p1);
    ev(2);
    f_set = 0;
    cmp();
    en <= 1'b0;
    repeat (24) @(posedge core_clk_i);
    lc = `UES_CODE_REFRESH;
    f_ref = 1;
    cmp();
    ev(2);
    cmp();
    hf <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    lc = `UES_CODE_HOST_FAULT;
    f_hf = 1;
    cmp();
    ev(2);
    cmp();
    hf <= 1'b0;
    en <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    ev(3);
    {f_hf, f_ref} = 2'b00;
    cmp();
    sd <= 1'b1;
    repeat (4) @(posedge core_clk_i);
    lc = `UES_CODE_SLOWDOWN;
    f_sd = 1;
    cmp();
    sd <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    ev(2);
    f_sd = 0;
    cmp();
    close_out();
  end
endmodule

`default_nettype wire
